// ==== hw/adc_frame_readout.sv ====
// converter-side serial readout: sample clock, data-ready and ten-word frames
// Function
// RQ1 - new sample set every oversampling period
// RQ2 - data-ready low on new samples; host starts
// RQ3 - host latches old set, lowers select
// RQ4 - frame is ten words of three bytes
// RQ5 - host sends all-zero no-operation command
// RQ6 - no-operation keeps configuration and state unchanged
// RQ7 - first word replies to previous command
// RQ8 - no-operation reply is status; host discards
// RQ9 - host sends zero dummy bytes after command
// RQ10 - channel 0 then channels 1-7 in order
// RQ11 - last word holds 16-bit crc, padded
// RQ12 - host clocks the padding byte too
// RQ13 - conversion continues during frame transfer
// RQ14 - host removes dc from signed samples
// RQ15 - host accumulates in 64-bit sums
// RQ16 - host flags result after mains cycles
// RQ17 - host swaps two accumulator sets
// RQ18 - host tracks period at zero crossings
// RQ19 - host swaps one-cycle rms sets
// RQ20 - host zero-crossing pin gated by threshold
// RQ21 - host keeps zero-crossing pin off leds
// RQ22 - host accumulates squares and products
// RQ23 - host raises select after thirtieth byte
module adc_frame_readout
    import adc_readout_pkg::*;
#(
    parameter int OVERSAMPLING_RATIO = OSR_DEFAULT,
    parameter int MOD_DIV = MOD_DIV_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [CHANNELS*WORD_BITS-1:0] sample_in,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic sample_avail_n,
    output logic [WORD_BITS-1:0] last_cmd_q,
    output logic frame_done_q
);
    localparam int CW = $clog2(OVERSAMPLING_RATIO);
    localparam int DW = $clog2(MOD_DIV) + 1;
    localparam int FRAME_BITS = FRAME_WORDS * WORD_BITS;

    initial begin
        if (OVERSAMPLING_RATIO < 2 || MOD_DIV < 1) begin
            $error("adc_frame_readout: bad OVERSAMPLING_RATIO or MOD_DIV");
        end
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
    endfunction : crc_step

    // pin synchronisers
    logic [1:0] sclk_s, cs_s, mosi_s;
    logic sclk_prev;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sclk_s <= 2'h0;
            cs_s <= 2'h3;
            mosi_s <= 2'h0;
            sclk_prev <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[0], spi_sclk};
            cs_s <= {cs_s[0], spi_cs_n};
            mosi_s <= {mosi_s[0], spi_mosi};
            sclk_prev <= sclk_s[1];
        end
    end
    wire sel = !cs_s[1];
    wire sclk_rise = sel && sclk_s[1] && !sclk_prev;
    wire sclk_fall = sel && !sclk_s[1] && sclk_prev;

    // modulator clock enable and oversampling counter
    logic [DW-1:0] div_q;
    logic [CW-1:0] osr_q;
    wire mod_tick = (div_q == DW'(MOD_DIV - 1));
    wire conv_done = mod_tick && (osr_q == CW'(OVERSAMPLING_RATIO - 1));
    // RQ1 oversampling period count
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            div_q <= '0;
            osr_q <= '0;
        end else begin
            div_q <= mod_tick ? '0 : div_q + DW'(1);
            if (mod_tick) begin
                osr_q <= (osr_q == CW'(OVERSAMPLING_RATIO - 1)) ? '0 : osr_q + CW'(1);
            end
        end
    end

    // RQ13 capture independent of frame
    logic [CHANNELS*WORD_BITS-1:0] conv_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            conv_q <= '0;
        end else if (conv_done) begin
            conv_q <= sample_in;
        end
    end

    // frame state
    logic [FRAME_BITS-1:0] shift_q;
    logic [8:0] bit_q;
    logic [WORD_BITS-1:0] cmd_q;
    logic [WORD_BITS-1:0] status_q;
    logic sel_prev;
    wire frame_start = sel && !sel_prev;
    wire frame_end = !sel && sel_prev;

    // RQ2 data-ready low on new set, high when select falls
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sample_avail_n <= 1'b1;
        end else if (conv_done) begin
            sample_avail_n <= 1'b0;
        end else if (frame_start) begin
            sample_avail_n <= 1'b1;
        end
    end

    // RQ7 reply word built from previous command
    // RQ8 no-operation reply is status
    // RQ10 channels follow in order
    // RQ11 crc in upper 16 bits, zero pad
    logic [FRAME_BITS-1:0] frame_img;
    always_comb begin
        logic [15:0] c;
        c = CRC_INIT;
        frame_img = {(cmd_q == NOOP_CMD) ? status_q : cmd_q, conv_q, 24'h000000};
        for (int i = FRAME_BITS - 1; i >= WORD_BITS; i--) begin
            c = crc_step(c, frame_img[i]);
        end
        frame_img[WORD_BITS-1:0] = {c, 8'h00};
    end

    // RQ4 ten words of 24 bits shifted
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sel_prev <= 1'b0;
            shift_q <= '0;
            bit_q <= '0;
            spi_miso <= 1'b0;
        end else begin
            sel_prev <= sel;
            if (frame_start) begin
                shift_q <= {frame_img[FRAME_BITS-2:0], 1'b0};
                spi_miso <= frame_img[FRAME_BITS-1];
                bit_q <= '0;
            end else if (sclk_fall && bit_q < 9'(FRAME_BITS)) begin
                spi_miso <= shift_q[FRAME_BITS-1];
                shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0};
            end
            if (sclk_rise && bit_q < 9'(FRAME_BITS)) begin
                bit_q <= bit_q + 9'h001;
            end
        end
    end

    // RQ6 command captured; no-operation changes nothing else
    logic [WORD_BITS-1:0] cmd_sr;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cmd_sr <= '0;
            cmd_q <= NOOP_CMD;
            status_q <= {16'h0000, STATUS_RESET};
            last_cmd_q <= NOOP_CMD;
            frame_done_q <= 1'b0;
        end else begin
            frame_done_q <= frame_end && bit_q == 9'(FRAME_BITS);
            if (sclk_rise && bit_q < 9'(WORD_BITS)) begin
                cmd_sr <= {cmd_sr[WORD_BITS-2:0], mosi_s[1]};
            end
            if (frame_end && bit_q >= 9'(WORD_BITS)) begin
                cmd_q <= cmd_sr;
                last_cmd_q <= cmd_sr;
            end
        end
    end

    // RQ2 data-ready falls one cycle after conversion
    a_sample_avail_n_fall: assert property (@(posedge sys_clk) disable iff (!resetn)
        conv_done && !frame_start |=> !sample_avail_n) // RQ2
        else $error("data-ready did not fall");
    a_osr_period: assert property (@(posedge sys_clk) disable iff (!resetn)
        conv_done |=> !conv_done [*2]) // RQ1
        else $error("conversion too soon");
    a_capture_ovl: assert property (@(posedge sys_clk) disable iff (!resetn)
        conv_done |=> conv_q == $past(sample_in)) // RQ13
        else $error("sample not captured");
    a_bit_bound: assert property (@(posedge sys_clk) disable iff (!resetn)
        bit_q <= 9'(FRAME_BITS)) // RQ4
        else $error("frame bit count overrun");
    a_noop_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
        frame_end && cmd_sr == NOOP_CMD && bit_q >= 9'(WORD_BITS) |=> status_q == $past(status_q)) // RQ6
        else $error("no-operation changed state");
    a_first_bit: assert property (@(posedge sys_clk) disable iff (!resetn)
        frame_start |=> spi_miso == $past(frame_img[FRAME_BITS-1])) // RQ7
        else $error("reply bit wrong");
    a_crc_pad: assert property (@(posedge sys_clk) disable iff (!resetn)
        frame_img[7:0] == 8'h00) // RQ11
        else $error("crc padding not zero");
    a_ch0_place: assert property (@(posedge sys_clk) disable iff (!resetn)
        frame_img[FRAME_BITS-WORD_BITS-1 -: WORD_BITS] == conv_q[CHANNELS*WORD_BITS-1 -: WORD_BITS]) // RQ10
        else $error("channel order wrong");
    a_sample_avail_n_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
        !sample_avail_n && !frame_start |=> !sample_avail_n) // RQ2
        else $error("data-ready rose without a frame");
    a_done_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
        frame_done_q |=> !frame_done_q) // RQ4
        else $error("done pulse too long");
    a_cmd_update: assert property (@(posedge sys_clk) disable iff (!resetn)
        frame_end && bit_q >= 9'(WORD_BITS) |=> last_cmd_q == $past(cmd_sr)) // RQ7
        else $error("command not taken");
    c_frame: cover property (@(posedge sys_clk) frame_done_q);
    c_noop: cover property (@(posedge sys_clk) frame_end && cmd_sr == NOOP_CMD);
    c_conv: cover property (@(posedge sys_clk) conv_done && sel);
    c_cmd: cover property (@(posedge sys_clk) frame_end && cmd_sr != NOOP_CMD);
endmodule : adc_frame_readout

// ==== hw/adc_readout_pkg.sv ====
// constants for the converter-side serial readout block
package adc_readout_pkg;
    localparam int WORD_BITS = 24;
    localparam int FRAME_WORDS = 10;
    localparam int CHANNELS = 8;
    localparam int OSR_DEFAULT = 512;
    localparam int MOD_DIV_DEFAULT = 4;
    localparam logic [23:0] NOOP_CMD = 24'h000000;
    localparam logic [7:0] STATUS_RESET = 8'h05;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [3:0] CRC_WORD_IDX = 4'h9;
endpackage : adc_readout_pkg

// ==== verification/host_spi_model.sv ====
// host serial master model: one ten-word frame on each data-ready fall
module host_spi_model
    import adc_readout_pkg::*;
(
    input wire logic sample_avail_n,
    input wire logic spi_miso,
    input wire logic [WORD_BITS-1:0] cmd,
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    output logic [FRAME_WORDS*WORD_BITS-1:0] rx_frame,
    output logic rx_done
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NB = FRAME_WORDS * WORD_BITS;
    logic [NB-1:0] tx_q;
    logic [NB-1:0] rx_q;
    localparam int mains_cycles_per_result = 10;
    localparam longint INTERRUPT_LEVEL = 64'h0000000000001000;
    logic [CHANNELS*WORD_BITS-1:0] prev_set;
    longint smp_v, smp_i, v_old, v_quarter, dc_v, dc_i;
    longint acc_q[2][4];
    longint rms_q[2];
    int work, rms_work, cyc, period, since_zc;
    logic result_due;
    logic zc_pin;
    initial begin
        {result_due, zc_pin} = 2'h1;
        prev_set = '0;
        {spi_sclk, spi_mosi, rx_done} = 3'h0;
        spi_cs_n = 1'b1;
        rx_frame = '0;
    end
    always @(negedge sample_avail_n) begin
        prev_set = rx_q[NB-WORD_BITS-1 -: CHANNELS*WORD_BITS];
        smp_v = longint'($signed(prev_set[CHANNELS*WORD_BITS-1 -: WORD_BITS])) - dc_v;
        smp_i = longint'($signed(prev_set[CHANNELS*WORD_BITS-WORD_BITS-1 -: WORD_BITS])) - dc_i;
        dc_v = dc_v + (smp_v >>> 8);
        dc_i = dc_i + (smp_i >>> 8);
        // squares and products in 64 bits
        acc_q[work][0] = acc_q[work][0] + smp_v * smp_v;
        acc_q[work][1] = acc_q[work][1] + smp_i * smp_i;
        acc_q[work][2] = acc_q[work][2] + smp_v * smp_i;
        acc_q[work][3] = acc_q[work][3] + smp_i * v_quarter;
        rms_q[rms_work] = rms_q[rms_work] + smp_v * smp_v;
        since_zc++;
        result_due = 1'b0;
        if (v_old < 0 && smp_v >= 0) begin
            period = since_zc;
            since_zc = 0;
            cyc++;
            rms_work = 1 - rms_work;
            rms_q[rms_work] = 0;
            if (rms_q[1 - rms_work] > INTERRUPT_LEVEL * period) begin
                zc_pin = 1'b0;
            end
        end else if (v_old >= 0 && smp_v < 0) begin
            if (rms_q[1 - rms_work] > INTERRUPT_LEVEL * period) begin
                zc_pin = 1'b1;
            end
        end
        if (cyc == mains_cycles_per_result) begin
            cyc = 0;
            result_due = 1'b1;
            work = 1 - work;
            acc_q[work] = '{default: 0};
        end
        v_quarter = v_old;
        v_old = smp_v;
        tx_q = {cmd, {(NB - WORD_BITS){1'b0}}};
        spi_cs_n = 1'b0;
        #100;
        for (int i = NB - 1; i >= 0; i--) begin
            spi_mosi = tx_q[i];
            #39 rx_q[i] = spi_miso;
            #1 spi_sclk = 1'b1;
            #40 spi_sclk = 1'b0;
        end
        spi_mosi = ~spi_mosi;
        #100;
        spi_cs_n = 1'b1;
        // reply word kept for checks only
        rx_frame = rx_q;
        rx_done = 1'b1;
        #10 rx_done = 1'b0;
    end
endmodule : host_spi_model

// ==== verification/testbench.sv ====
// self-checking bench for the converter-side readout block
module testbench;
    import adc_readout_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int OSR_T = 64;
    localparam int DIV_T = 64;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [CHANNELS*WORD_BITS-1:0] sample_in = '0;
    logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, sample_avail_n, frame_done_q, rx_done;
    logic [WORD_BITS-1:0] last_cmd_q;
    logic [WORD_BITS-1:0] cmd = '0;
    logic [WORD_BITS-1:0] prev_cmd = '0;
    logic [FRAME_WORDS*WORD_BITS-1:0] rx_frame, exp_frame;
    logic [CHANNELS*WORD_BITS-1:0] exp_q[$];
    int bad_count = 0;
    int cmp_count = 0;
    int gap = 0;
    int falls = 0;
    always #5 sys_clk = ~sys_clk;
    adc_frame_readout #(.OVERSAMPLING_RATIO(OSR_T), .MOD_DIV(DIV_T)) dut_u (.sys_clk(sys_clk),
        .resetn(resetn), .sample_in(sample_in), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .sample_avail_n(sample_avail_n),
        .last_cmd_q(last_cmd_q), .frame_done_q(frame_done_q));
    host_spi_model host_u (.sample_avail_n(sample_avail_n), .spi_miso(spi_miso), .cmd(cmd),
        .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
        .rx_frame(rx_frame), .rx_done(rx_done));
    task automatic check(input logic [239:0] got, input logic [239:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check
    task automatic close_out();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    function automatic logic [15:0] crc16(input logic [215:0] d);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 215; i >= 0; i--) begin
            c = (c[15] ^ d[i]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc16
    always @(posedge sys_clk) gap++;
    always @(negedge sample_avail_n) begin
        exp_q.push_back(sample_in);
        falls++;
        if (falls > 1) check(gap, OSR_T * DIV_T, "sample period");
        gap = 0;
        @(posedge sys_clk);
        #1 sample_in = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    end
    initial begin
        #400us;
        bad_count++;
        close_out();
    end
    initial begin
        void'($urandom(32'hC2802F53));
        repeat (4) @(posedge sys_clk);
        #1 resetn = 1'b1;
        for (int f = 0; f < 6; f++) begin
            @(posedge rx_done);
            exp_frame[239:216] = (prev_cmd === NOOP_CMD) ? {16'h0000, STATUS_RESET} : prev_cmd;
            exp_frame[215:24] = exp_q.pop_front();
            exp_frame[23:0] = {crc16(exp_frame[239:24]), 8'h00};
            check(rx_frame, exp_frame, "frame");
            check(sample_avail_n, 1'b1, "ready cleared");
            for (int n = 0; n < 20 && frame_done_q !== 1'b1; n++) begin
                @(posedge sys_clk);
                #1;
            end
            check(frame_done_q, 1'b1, "done pulse");
            @(posedge sys_clk);
            #1 check(last_cmd_q, cmd, "command");
            prev_cmd = cmd;
            cmd = (f == 1 || f == 3) ? (24'($urandom) | 24'h000100) : NOOP_CMD;
        end
        close_out();
    end
endmodule : testbench
